// file: gpp_bank.v
`timescale 1ns/10ps
`include "gpp_defs.vh"

module gpp_bank #(
  parameter WIDTH = 8
) (
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire             data_we_i,
  input  wire             dir_we_i,
  input  wire [7:0]       wdata_i,
  input  wire [WIDTH-1:0] pin_i,
  output reg  [WIDTH-1:0] data_o,
  output reg  [WIDTH-1:0] dir_o,
  output reg  [WIDTH-1:0] pin_oe_o,
  output reg  [WIDTH-1:0] pin_level_o
);

  reg [WIDTH-1:0] sync_first_reg;

  always @(posedge clk_i) begin
    if (rst_i) begin
      sync_first_reg <= {WIDTH{1'b0}};
      pin_level_o    <= {WIDTH{1'b0}};
    end else begin
      sync_first_reg <= pin_i;
      pin_level_o    <= sync_first_reg;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      data_o <= {WIDTH{1'b1}};
    end else if (data_we_i) begin
      data_o <= wdata_i[WIDTH-1:0];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      dir_o    <= {WIDTH{1'b1}};
      pin_oe_o <= {WIDTH{1'b0}};
    end else if (dir_we_i) begin
      dir_o    <= wdata_i[WIDTH-1:0];
      pin_oe_o <= ~wdata_i[WIDTH-1:0];
    end
  end

endmodule

// file: gpp_defs.vh
`ifndef GPP_DEFS_VH
`define GPP_DEFS_VH

// Register indices. The byte address of a register is four times its index.
`define GPP_IDX_PORT0_DATA    8'h80
`define GPP_IDX_PORT1_DATA    8'h90
`define GPP_IDX_PORT2_DATA    8'hA0
`define GPP_IDX_PORT0_DIR     8'hA4
`define GPP_IDX_PORT1_DIR     8'hA5
`define GPP_IDX_PORT2_DIR     8'hA6
`define GPP_IDX_PORT3_DIR     8'hA7
`define GPP_IDX_PORT3_DATA    8'hB0

// Bus address layout.
`define GPP_ADDR_W            12
`define GPP_IDX_LSB           2
`define GPP_IDX_MSB           9
`define GPP_VIEW_BIT          10
`define GPP_TOP_BIT           11

// Port widths.
`define GPP_PORT0_W           4
`define GPP_PORT1_W           8
`define GPP_PORT2_W           8
`define GPP_PORT3_W           6
`define GPP_REG_W             8

// Reset values and bus answers.
`define GPP_RST_ONES          8'hFF
`define GPP_ZERO32            32'h00000000
`define GPP_RESP_OKAY         2'h0
`define GPP_RESP_SLVERR       2'h2
`define GPP_SYNC_ZERO         8'h00

`endif

// file: gpp_monitor.sv
`timescale 1ns/10ps
module gpp_monitor (
  input wire        CLK_I,
  input wire        RESET_I,
  input wire        AWVALID_I,
  input wire        AWREADY_O,
  input wire        WVALID_I,
  input wire        WREADY_O,
  input wire        BVALID_O,
  input wire        BREADY_I,
  input wire [1:0]  BRESP_O,
  input wire        ARVALID_I,
  input wire        ARREADY_O,
  input wire        RVALID_O,
  input wire        RREADY_I,
  input wire [31:0] RDATA_O,
  input wire [7:0]  PORT1_PIN_O,
  input wire [7:0]  PORT1_PIN_OE_O,
  input wire [5:0]  PORT3_PIN_O,
  input wire [5:0]  PORT3_PIN_OE_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  sequence wr_take;
    AWVALID_I && AWREADY_O && WVALID_I && WREADY_O;
  endsequence
  sequence rd_take;
    ARVALID_I && ARREADY_O;
  endsequence
  rst_state_a: assert property (disable iff (1'h0) RESET_I |=>
    PORT1_PIN_OE_O == 8'h00 && PORT1_PIN_O == 8'hFF && PORT3_PIN_OE_O == 6'h00 && PORT3_PIN_O == 6'h3F)
    else $error("pins not at reset state");
  wr_answer_a: assert property (wr_take |=> !BVALID_O ##1 BVALID_O)
    else $error("write response late");
  rd_answer_a: assert property (rd_take |=> RVALID_O)
    else $error("read response late");
  b_hold_a: assert property (BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O))
    else $error("write response dropped");
  r_hold_a: assert property (RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O))
    else $error("read data dropped");
  wr_busy_a: assert property (BVALID_O |-> !AWREADY_O && !WREADY_O)
    else $error("write taken while busy");
  rd_busy_a: assert property (RVALID_O |-> !ARREADY_O)
    else $error("read taken while busy");
  pin_cause_a: assert property ($changed({PORT1_PIN_O, PORT1_PIN_OE_O, PORT3_PIN_O, PORT3_PIN_OE_O})
    |-> BVALID_O) else $error("pin changed without write");
endmodule

// file: gpp_top.v
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/10ps
`include "gpp_defs.vh"

// Summary of operation
// - Port one data register: eight read/write bits, reset to all ones.
// - Port two data register: eight read/write bits, reset to all ones.
// - Port three data: bits 5..0 read/write, reset ones; bits 7..6 read zero.
// - Port zero direction: bits 3..0 reset ones; bits 7..4 read zero.
// - Port one direction: eight read/write bits, reset to ones.
// - Port two direction: eight read/write bits, reset to ones.
// - Port three direction: bits 5..0 reset ones; bits 7..6 read zero.
// - Direction bit zero makes the pin a driven output.
// - Direction bit one leaves the pin undriven; all pins inputs after reset.
// - Plain data register read returns sampled pin levels.
// - Read-modify-write path reads the stored output latch regardless of direction.
// - Data register write updates the latch, driven on output pins.

module gpp_top (
  input  wire                     CLK_I,
  input  wire                     RESET_I,
  input  wire                     AWVALID_I,
  input  wire [`GPP_ADDR_W-1:0]   AWADDR_I,
  input  wire [2:0]               AWPROT_I,
  output reg                      AWREADY_O,
  input  wire                     WVALID_I,
  input  wire [31:0]              WDATA_I,
  input  wire [3:0]               WSTRB_I,
  output reg                      WREADY_O,
  output reg                      BVALID_O,
  output reg  [1:0]               BRESP_O,
  input  wire                     BREADY_I,
  input  wire                     ARVALID_I,
  input  wire [`GPP_ADDR_W-1:0]   ARADDR_I,
  input  wire [2:0]               ARPROT_I,
  output reg                      ARREADY_O,
  output reg                      RVALID_O,
  output reg  [31:0]              RDATA_O,
  output reg  [1:0]               RRESP_O,
  input  wire                     RREADY_I,
  input  wire [`GPP_PORT0_W-1:0]  PORT0_PIN_I,
  output wire [`GPP_PORT0_W-1:0]  PORT0_PIN_O,
  output wire [`GPP_PORT0_W-1:0]  PORT0_PIN_OE_O,
  input  wire [`GPP_PORT1_W-1:0]  PORT1_PIN_I,
  output wire [`GPP_PORT1_W-1:0]  PORT1_PIN_O,
  output wire [`GPP_PORT1_W-1:0]  PORT1_PIN_OE_O,
  input  wire [`GPP_PORT2_W-1:0]  PORT2_PIN_I,
  output wire [`GPP_PORT2_W-1:0]  PORT2_PIN_O,
  output wire [`GPP_PORT2_W-1:0]  PORT2_PIN_OE_O,
  input  wire [`GPP_PORT3_W-1:0]  PORT3_PIN_I,
  output wire [`GPP_PORT3_W-1:0]  PORT3_PIN_O,
  output wire [`GPP_PORT3_W-1:0]  PORT3_PIN_OE_O
);

  reg  [`GPP_ADDR_W-1:0]  wr_addr_reg;
  reg  [7:0]              wr_data_reg;
  reg                     wr_lane_reg;
  reg                     have_addr_reg;
  reg                     have_data_reg;

  wire                    aw_take;
  wire                    w_take;
  wire                    ar_take;
  wire                    wr_go;
  wire [7:0]              wr_idx;
  wire                    wr_hit;
  wire                    wr_en;
  wire [7:0]              rd_idx;
  wire                    rd_view_latch;

  wire [`GPP_PORT0_W-1:0] port_zero_data;
  wire [`GPP_PORT1_W-1:0] port_one_data;
  wire [`GPP_PORT2_W-1:0] port_two_data;
  wire [`GPP_PORT3_W-1:0] port_three_data;
  wire [`GPP_PORT0_W-1:0] port_zero_direction;
  wire [`GPP_PORT1_W-1:0] port_one_direction;
  wire [`GPP_PORT2_W-1:0] port_two_direction;
  wire [`GPP_PORT3_W-1:0] port_three_direction;
  wire [`GPP_PORT0_W-1:0] port_zero_level;
  wire [`GPP_PORT1_W-1:0] port_one_level;
  wire [`GPP_PORT2_W-1:0] port_two_level;
  wire [`GPP_PORT3_W-1:0] port_three_level;

  reg  [7:0]              rd_byte;
  reg                     rd_hit;

  assign aw_take       = AWVALID_I & AWREADY_O;
  assign w_take        = WVALID_I & WREADY_O;
  assign ar_take       = ARVALID_I & ARREADY_O;
  assign wr_go         = have_addr_reg & have_data_reg & ~BVALID_O;
  assign wr_idx        = wr_addr_reg[`GPP_IDX_MSB:`GPP_IDX_LSB];
  assign rd_idx        = ARADDR_I[`GPP_IDX_MSB:`GPP_IDX_LSB];
  assign rd_view_latch = ARADDR_I[`GPP_VIEW_BIT];

  assign wr_hit = ~wr_addr_reg[`GPP_TOP_BIT] &
                  ((wr_idx == `GPP_IDX_PORT0_DATA) | (wr_idx == `GPP_IDX_PORT1_DATA) |
                   (wr_idx == `GPP_IDX_PORT2_DATA) | (wr_idx == `GPP_IDX_PORT3_DATA) |
                   (wr_idx == `GPP_IDX_PORT0_DIR)  | (wr_idx == `GPP_IDX_PORT1_DIR)  |
                   (wr_idx == `GPP_IDX_PORT2_DIR)  | (wr_idx == `GPP_IDX_PORT3_DIR));
  assign wr_en  = wr_go & wr_hit & wr_lane_reg;

  // Write address and data are caught in either order.
  always @(posedge CLK_I) begin
    if (RESET_I) begin
      AWREADY_O     <= 1'b0;
      WREADY_O      <= 1'b0;
      have_addr_reg <= 1'b0;
      have_data_reg <= 1'b0;
      wr_addr_reg   <= {`GPP_ADDR_W{1'b0}};
      wr_data_reg   <= `GPP_SYNC_ZERO;
      wr_lane_reg   <= 1'b0;
      BVALID_O      <= 1'b0;
      BRESP_O       <= `GPP_RESP_OKAY;
    end else begin
      if (aw_take) begin
        AWREADY_O     <= 1'b0;
        have_addr_reg <= 1'b1;
        wr_addr_reg   <= AWADDR_I;
      end else if (~have_addr_reg & ~BVALID_O) begin
        AWREADY_O <= 1'b1;
      end
      if (w_take) begin
        WREADY_O      <= 1'b0;
        have_data_reg <= 1'b1;
        wr_data_reg   <= WDATA_I[7:0];
        wr_lane_reg   <= WSTRB_I[0];
      end else if (~have_data_reg & ~BVALID_O) begin
        WREADY_O <= 1'b1;
      end
      if (wr_go) begin
        have_addr_reg <= 1'b0;
        have_data_reg <= 1'b0;
        BVALID_O      <= 1'b1;
        BRESP_O       <= wr_hit ? `GPP_RESP_OKAY : `GPP_RESP_SLVERR;
      end else if (BVALID_O & BREADY_I) begin
        BVALID_O <= 1'b0;
      end
    end
  end

  // Read data selection.
  always @* begin
    rd_byte = `GPP_SYNC_ZERO;
    rd_hit  = ~ARADDR_I[`GPP_TOP_BIT];
    case (rd_idx)
      `GPP_IDX_PORT0_DATA: begin
        rd_byte = rd_view_latch ? {4'h0, port_zero_data} : {4'h0, port_zero_level};
      end
      `GPP_IDX_PORT1_DATA: begin
        rd_byte = rd_view_latch ? port_one_data : port_one_level;
      end
      `GPP_IDX_PORT2_DATA: begin
        rd_byte = rd_view_latch ? port_two_data : port_two_level;
      end
      `GPP_IDX_PORT3_DATA: begin
        rd_byte = rd_view_latch ? {2'h0, port_three_data} : {2'h0, port_three_level};
      end
      `GPP_IDX_PORT0_DIR: begin
        rd_byte = {4'h0, port_zero_direction};
      end
      `GPP_IDX_PORT1_DIR: begin
        rd_byte = port_one_direction;
      end
      `GPP_IDX_PORT2_DIR: begin
        rd_byte = port_two_direction;
      end
      `GPP_IDX_PORT3_DIR: begin
        rd_byte = {2'h0, port_three_direction};
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // Read channel answers one cycle after the address is taken.
  always @(posedge CLK_I) begin
    if (RESET_I) begin
      ARREADY_O <= 1'b0;
      RVALID_O  <= 1'b0;
      RDATA_O   <= `GPP_ZERO32;
      RRESP_O   <= `GPP_RESP_OKAY;
    end else begin
      if (ar_take) begin
        ARREADY_O <= 1'b0;
        RVALID_O  <= 1'b1;
        RDATA_O   <= rd_hit ? {24'h000000, rd_byte} : `GPP_ZERO32;
        RRESP_O   <= rd_hit ? `GPP_RESP_OKAY : `GPP_RESP_SLVERR;
      end else if (RVALID_O & RREADY_I) begin
        RVALID_O <= 1'b0;
      end else if (~RVALID_O) begin
        ARREADY_O <= 1'b1;
      end
    end
  end

  // Port banks; output pins show the latch, enables are the inverse of direction.
  gpp_bank #(
    .WIDTH(`GPP_PORT0_W)
  ) u_port0 (
    .clk_i       (CLK_I),
    .rst_i       (RESET_I),
    .data_we_i   (wr_en & (wr_idx == `GPP_IDX_PORT0_DATA)),
    .dir_we_i    (wr_en & (wr_idx == `GPP_IDX_PORT0_DIR)),
    .wdata_i     (wr_data_reg),
    .pin_i       (PORT0_PIN_I),
    .data_o      (port_zero_data),
    .dir_o       (port_zero_direction),
    .pin_oe_o    (PORT0_PIN_OE_O),
    .pin_level_o (port_zero_level)
  );

  gpp_bank #(
    .WIDTH(`GPP_PORT1_W)
  ) u_port1 (
    .clk_i       (CLK_I),
    .rst_i       (RESET_I),
    .data_we_i   (wr_en & (wr_idx == `GPP_IDX_PORT1_DATA)),
    .dir_we_i    (wr_en & (wr_idx == `GPP_IDX_PORT1_DIR)),
    .wdata_i     (wr_data_reg),
    .pin_i       (PORT1_PIN_I),
    .data_o      (port_one_data),
    .dir_o       (port_one_direction),
    .pin_oe_o    (PORT1_PIN_OE_O),
    .pin_level_o (port_one_level)
  );

  gpp_bank #(
    .WIDTH(`GPP_PORT2_W)
  ) u_port2 (
    .clk_i       (CLK_I),
    .rst_i       (RESET_I),
    .data_we_i   (wr_en & (wr_idx == `GPP_IDX_PORT2_DATA)),
    .dir_we_i    (wr_en & (wr_idx == `GPP_IDX_PORT2_DIR)),
    .wdata_i     (wr_data_reg),
    .pin_i       (PORT2_PIN_I),
    .data_o      (port_two_data),
    .dir_o       (port_two_direction),
    .pin_oe_o    (PORT2_PIN_OE_O),
    .pin_level_o (port_two_level)
  );

  gpp_bank #(
    .WIDTH(`GPP_PORT3_W)
  ) u_port3 (
    .clk_i       (CLK_I),
    .rst_i       (RESET_I),
    .data_we_i   (wr_en & (wr_idx == `GPP_IDX_PORT3_DATA)),
    .dir_we_i    (wr_en & (wr_idx == `GPP_IDX_PORT3_DIR)),
    .wdata_i     (wr_data_reg),
    .pin_i       (PORT3_PIN_I),
    .data_o      (port_three_data),
    .dir_o       (port_three_direction),
    .pin_oe_o    (PORT3_PIN_OE_O),
    .pin_level_o (port_three_level)
  );

  assign PORT0_PIN_O = port_zero_data;
  assign PORT1_PIN_O = port_one_data;
  assign PORT2_PIN_O = port_two_data;
  assign PORT3_PIN_O = port_three_data;

endmodule

// file: test_gpp_top.sv
`timescale 1ns/10ps
`include "gpp_defs.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; $display("mismatch at %0t: %h vs %h", $time, g, e); end end
module test_gpp_top;
  logic        CLK_I = 0, RESET_I = 1, AWVALID_I = 0, WVALID_I = 0, BREADY_I = 0, ARVALID_I = 0, RREADY_I = 0;
  logic [11:0] AWADDR_I = 0, ARADDR_I = 0;
  logic [2:0]  AWPROT_I = 0, ARPROT_I = 0;
  logic [31:0] WDATA_I = 0;
  logic [3:0]  WSTRB_I = 0, PORT0_PIN_I = 0;
  logic [7:0]  PORT1_PIN_I = 0, PORT2_PIN_I = 0;
  logic [5:0]  PORT3_PIN_I = 0;
  wire         AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O;
  wire  [1:0]  BRESP_O, RRESP_O;
  wire  [31:0] RDATA_O;
  wire  [3:0]  PORT0_PIN_O, PORT0_PIN_OE_O;
  wire  [7:0]  PORT1_PIN_O, PORT1_PIN_OE_O, PORT2_PIN_O, PORT2_PIN_OE_O;
  wire  [5:0]  PORT3_PIN_O, PORT3_PIN_OE_O;
  wire  [25:0] oe_all = {PORT0_PIN_OE_O, PORT1_PIN_OE_O, PORT2_PIN_OE_O, PORT3_PIN_OE_O};
  wire  [25:0] pin_all = {PORT0_PIN_O, PORT1_PIN_O, PORT2_PIN_O, PORT3_PIN_O};
  int          n_fail = 0, n_tests = 0, cyc = 0, seed = 32'h33CA, r;
  logic [33:0] exp_q[$], e;
  logic [7:0]  wv[8], pv[4];
  logic [7:0]  idx[8] = '{`GPP_IDX_PORT0_DATA, `GPP_IDX_PORT1_DATA, `GPP_IDX_PORT2_DATA, `GPP_IDX_PORT3_DATA,
                          `GPP_IDX_PORT0_DIR, `GPP_IDX_PORT1_DIR, `GPP_IDX_PORT2_DIR, `GPP_IDX_PORT3_DIR};
  logic [7:0]  msk[8] = '{8'h0F, 8'hFF, 8'hFF, 8'h3F, 8'h0F, 8'hFF, 8'hFF, 8'h3F};
  gpp_top gpp_top_inst (.*);
  always #2 CLK_I = ~CLK_I;
  always @(posedge CLK_I) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      close_out;
    end
  end
  always @(posedge CLK_I) begin
    if ((BVALID_O && BREADY_I) || (RVALID_O && RREADY_I)) begin
      e = exp_q.pop_front();
      `CHK(BVALID_O ? {BRESP_O, 32'h0} : {RRESP_O, RDATA_O}, e)
    end
  end
  function logic [11:0] ad(input logic v, input logic [7:0] i);
    return {1'h0, v, i, 2'h0};
  endfunction
  task wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] rs);
    r = $random(seed);
    exp_q.push_back({rs, 32'h0});
    @(posedge CLK_I);
    AWVALID_I <= 1;
    WVALID_I <= 1;
    AWADDR_I <= a;
    AWPROT_I <= r[2:0];
    WDATA_I <= {r[31:8], d};
    WSTRB_I <= s;
    BREADY_I <= r[9];
    fork
      begin do @(posedge CLK_I); while (!AWREADY_O); AWVALID_I <= 0; end
      begin do @(posedge CLK_I); while (!WREADY_O); WVALID_I <= 0; end
    join
    while (1) begin @(posedge CLK_I); if (BVALID_O && BREADY_I) break; if (BVALID_O) BREADY_I <= 1; end
    BREADY_I <= 0;
  endtask
  task rd(input logic [11:0] a, input logic [33:0] x);
    r = $random(seed);
    exp_q.push_back(x);
    @(posedge CLK_I);
    ARVALID_I <= 1;
    ARADDR_I <= a;
    ARPROT_I <= r[2:0];
    RREADY_I <= r[9];
    do @(posedge CLK_I); while (!ARREADY_O);
    ARVALID_I <= 0;
    while (1) begin @(posedge CLK_I); if (RVALID_O && RREADY_I) break; if (RVALID_O) RREADY_I <= 1; end
    RREADY_I <= 0;
  endtask
  task rst_chk;
    RESET_I <= 1;
    repeat (8) @(posedge CLK_I);
    RESET_I <= 0;
    for (int i = 0; i < 8; i++) rd(ad(1, idx[i]), {`GPP_RESP_OKAY, 24'h0, msk[i]});
    `CHK(oe_all, 26'h0)
    `CHK(pin_all, 26'h3FFFFFF)
    $display("reset values test done");
  endtask
  task close_out;
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    rst_chk;
    for (int i = 0; i < 8; i++) begin
      wv[i] = $random(seed);
      wr(ad(i[0], idx[i]), wv[i], 4'h1, `GPP_RESP_OKAY);
    end
    for (int i = 0; i < 8; i++) rd(ad(1, idx[i]), {`GPP_RESP_OKAY, 24'h0, wv[i] & msk[i]});
    `CHK(pin_all, {wv[0][3:0], wv[1], wv[2], wv[3][5:0]})
    `CHK(oe_all, ~{wv[4][3:0], wv[5], wv[6], wv[7][5:0]})
    $display("write and readback test done");
    r = $random(seed);
    @(posedge CLK_I);
    {PORT0_PIN_I, PORT1_PIN_I, PORT2_PIN_I, PORT3_PIN_I} <= r[25:0];
    repeat (2) @(posedge CLK_I);
    pv = '{{4'h0, r[25:22]}, r[21:14], r[13:6], {2'h0, r[5:0]}};
    for (int i = 0; i < 4; i++) rd(ad(0, idx[i]), {`GPP_RESP_OKAY, 24'h0, pv[i]});
    rd(ad(1, idx[2]), {`GPP_RESP_OKAY, 24'h0, wv[2]});
    $display("pin sampling test done");
    wr(ad(0, idx[1]), ~wv[1], 4'h0, `GPP_RESP_OKAY);
    wr(12'h004, 8'h55, 4'h1, `GPP_RESP_SLVERR);
    wr(12'h800 | ad(0, idx[1]), ~wv[1], 4'h1, `GPP_RESP_SLVERR);
    rd(ad(1, idx[1]), {`GPP_RESP_OKAY, 24'h0, wv[1]});
    rd(12'h004, {`GPP_RESP_SLVERR, 32'h0});
    $display("refused access test done");
    rst_chk;
    close_out;
  end
endmodule
bind gpp_top gpp_monitor gpp_monitor_inst (.*);
